// >>> sbt_host.sv
// sbt_host: controller end; axi4-lite slave, device register sequencer
// and prbs7 transmitter for all lanes
// assumes: software issues one command at a time and polls busy
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module sbt_host
  import sbt_pkg::*;
(
  input  wire logic        clk_i,          // 200 MHz clock
  input  wire logic        rst_n_i,        // synchronous reset, active low
  sbt_link_if.host         link,           // register port and lanes
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic  [3:0] s_axi_awaddr,   // write address
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic  [3:0] s_axi_wstrb,    // byte enables
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  output logic       [1:0] s_axi_bresp,    // write response
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  input  wire logic  [3:0] s_axi_araddr,   // read address
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready,   // read data ready
  output logic      [31:0] s_axi_rdata,    // read data
  output logic       [1:0] s_axi_rresp     // read response
);
  // all state of the controller
  typedef struct packed {
    logic           aw_rdy;    // address and data taken together
    logic           bvalid;
    logic [1:0]     bresp;
    logic           ar_rdy;
    logic           rvalid;
    logic [1:0]     rresp;
    logic [31:0]    rdata;
    logic [31:0]    cmd;       // pending device command
    sbt_cmd_state_t cstate;    // sequencer state
    logic [7:0]     dev_rdata; // last device read data
    logic           refused;   // last command dropped
    logic           tx_en;     // transmitter on (stands for link_enable)
    logic [15:0]    inject;    // one-shot bit flips
    logic [6:0]     prbs;      // transmit pattern state
    logic [15:0]    lanes;     // driven lane bits
    logic           timing;    // measurement timer running
    logic [31:0]    timer;     // measurement_elapsed_time in cycles
    logic [11:0]    addr;      // device register port drive
    logic [7:0]     wdata;
    logic           wr;
    logic           rd;
  } sbt_host_t;

  sbt_host_t   st;        // registered state
  sbt_host_t   next_st;   // next state
  logic        w_take;    // write handshake this cycle
  logic        r_take;    // read handshake this cycle
  logic [31:0] wmask;     // byte enables widened
  logic        prbs_bit;  // next transmit bit
  logic        is_wr;     // command is a write
  logic        bad_cmd;   // command breaks the setup order

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_st  = st;
    w_take   = st.aw_rdy && s_axi_awvalid && s_axi_wvalid;
    r_take   = st.ar_rdy && s_axi_arvalid;
    wmask    = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    prbs_bit = st.prbs[6] ^ st.prbs[5];
    is_wr    = st.cmd[SBT_CMD_WR_BIT];
    // receiver control only with link off; test enable only with link on
    bad_cmd  = is_wr && (((st.cmd[11:0] == SBT_ADDR_RX_CTRL) && st.tx_en) ||
               ((st.cmd[11:0] == SBT_ADDR_TEST_CTRL) && st.cmd[16] && !st.tx_en));
    // axi write: ready for one cycle when both channels wait
    next_st.aw_rdy = s_axi_awvalid && s_axi_wvalid && !st.aw_rdy && !st.bvalid;
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.inject = '0;
    if (w_take) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = SBT_RESP_OKAY;
      case (s_axi_awaddr)
        SBT_H_CMD: begin
          if (st.cstate == SBT_IDLE) begin
            next_st.cmd    = (st.cmd & ~wmask) | (s_axi_wdata & wmask);
            next_st.cstate = SBT_ISSUE;
          end
        end
        SBT_H_TX: begin
          if (s_axi_wstrb[0]) begin
            next_st.tx_en = s_axi_wdata[0];
          end
          next_st.inject = s_axi_wdata[31:16] & wmask[31:16];
        end
        SBT_H_STAT, SBT_H_TIMER: ;  // read only, write ignored
        default: next_st.bresp = SBT_RESP_SLVERR;
      endcase
    end
    // axi read
    next_st.ar_rdy = s_axi_arvalid && !st.ar_rdy && !st.rvalid;
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    if (r_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = SBT_RESP_OKAY;
      case (s_axi_araddr)
        SBT_H_CMD:   next_st.rdata = st.cmd;
        SBT_H_STAT:  next_st.rdata = {22'h0, st.refused, (st.cstate != SBT_IDLE),
                                      st.dev_rdata};
        SBT_H_TX:    next_st.rdata = {16'h0, 15'h0, st.tx_en};
        SBT_H_TIMER: next_st.rdata = st.timer;
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = SBT_RESP_SLVERR;
        end
      endcase
    end
    // measurement timer; the sequencer below may clear it in the same cycle
    if (st.timing && (st.timer != 32'hffffffff)) begin
      next_st.timer = st.timer + 32'h1;
    end
    // device register sequencer
    next_st.wr = 1'b0;
    next_st.rd = 1'b0;
    case (st.cstate)
      SBT_IDLE: ;
      SBT_ISSUE: begin
        next_st.refused = bad_cmd;
        next_st.addr    = st.cmd[11:0];
        next_st.wdata   = st.cmd[23:16];
        if (bad_cmd) begin
          next_st.cstate = SBT_IDLE;
        end else if (is_wr) begin
          next_st.wr     = 1'b1;
          next_st.cstate = SBT_IDLE;
          if (st.cmd[11:0] == SBT_ADDR_TEST_CTRL) begin
            // timer restarts on every enable write, stops and clears to zero on disable
            next_st.timing = st.cmd[16];
            next_st.timer  = 32'h0;
          end
        end else if (st.cmd[SBT_CMD_RD_BIT]) begin
          next_st.rd     = 1'b1;
          next_st.cstate = SBT_WAIT_RD;
        end else begin
          next_st.cstate = SBT_IDLE;
        end
      end
      SBT_WAIT_RD: begin
        if (link.reg_rvalid) begin
          next_st.dev_rdata = link.reg_rdata;
          next_st.cstate    = SBT_IDLE;
        end
      end
      default: next_st.cstate = SBT_IDLE;
    endcase
    // prbs7 transmitter, identical on all lanes, optional flips
    if (st.tx_en) begin
      next_st.prbs  = {st.prbs[5:0], prbs_bit};
      next_st.lanes = {SBT_LANES{prbs_bit}} ^ st.inject;
    end else begin
      next_st.prbs  = SBT_PRBS_SEED;
      next_st.lanes = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st        <= '0;
      st.cstate <= SBT_IDLE;
      st.prbs   <= SBT_PRBS_SEED;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign s_axi_awready  = st.aw_rdy;
  assign s_axi_wready   = st.aw_rdy;
  assign s_axi_bvalid   = st.bvalid;
  assign s_axi_bresp    = st.bresp;
  assign s_axi_arready  = st.ar_rdy;
  assign s_axi_rvalid   = st.rvalid;
  assign s_axi_rdata    = st.rdata;
  assign s_axi_rresp    = st.rresp;
  assign link.reg_addr  = st.addr;
  assign link.reg_wdata = st.wdata;
  assign link.reg_wr    = st.wr;
  assign link.reg_rd    = st.rd;
  assign link.lane_bit  = st.lanes;
endmodule : sbt_host
`default_nettype wire

// >>> sbt_pkg.sv
// sbt_pkg: constants and types shared by the bit-error test ends
// assumes: included first in compile order; one clock at 200 MHz
`default_nettype none
package sbt_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // device register map (byte addresses on the device register port)
  localparam logic [11:0] SBT_ADDR_TEST_CTRL = 12'h1a0;  // bit_error_test_control
  localparam logic [11:0] SBT_ADDR_LANE_CNT  = 12'h1b0;  // lane_error_counter, lane 0
  localparam logic [11:0] SBT_ADDR_RX_CTRL   = 12'h1c1;  // serdes_receiver_control
  localparam logic [7:0]  SBT_TEST_CTRL_RST  = 8'h00;    // test control reset value
  localparam logic [7:0]  SBT_RX_CTRL_RST    = 8'h43;    // receiver control reset value
  localparam int          SBT_TEST_EN_BIT    = 0;        // error_test_enable position
  localparam int          SBT_CDR_LSB        = 4;        // clock_recovery_setting bits 6-4
  localparam int          SBT_OC_BIT         = 1;        // offset_cal_enable position
  localparam int          SBT_LOS_BIT        = 0;        // signal_loss_detect_enable position
  localparam int          SBT_LANES          = 16;       // serial lanes
  localparam int          SBT_PRBS_LEN       = 7;        // checker pattern length (prbs7)
  localparam logic [7:0]  SBT_CNT_MAX        = 8'hff;    // counter saturation value
  // clock recovery figures
  localparam logic [10:0] SBT_SETTLE_FAST_UI = 11'd36;   // settling time, settings 0-6
  localparam logic [10:0] SBT_SETTLE_SLOW_UI = 11'd1524; // settling time, setting 7
  ////////////////////////////////////////////////////////////////////////////
  // controller (host end) axi4-lite register map
  localparam logic [3:0]  SBT_H_CMD    = 4'h0;  // [11:0] addr [23:16] data [24] wr [25] rd
  localparam logic [3:0]  SBT_H_STAT   = 4'h4;  // [7:0] read data [8] busy [9] refused
  localparam logic [3:0]  SBT_H_TX     = 4'h8;  // [0] tx enable [31:16] error inject mask
  localparam logic [3:0]  SBT_H_TIMER  = 4'hc;  // cycles since error test enable was set
  localparam int          SBT_CMD_WR_BIT = 24;  // command write request
  localparam int          SBT_CMD_RD_BIT = 25;  // command read request
  localparam logic [1:0]  SBT_RESP_OKAY   = 2'b00;  // axi okay
  localparam logic [1:0]  SBT_RESP_SLVERR = 2'b10;  // axi slave error
  localparam logic [6:0]  SBT_PRBS_SEED   = 7'h7f;  // transmitter start state

  // controller command sequencer states
  typedef enum logic [1:0] {SBT_IDLE, SBT_ISSUE, SBT_WAIT_RD} sbt_cmd_state_t;
endpackage : sbt_pkg
`default_nettype wire

// >>> sbt_link_if.sv
// sbt_link_if: register port and serial lanes between controller and device
// assumes: one clock shared by both ends; the bench joins the modports
`timescale 1ns/100ps
`default_nettype none
interface sbt_link_if;
  logic [11:0] reg_addr;    // register byte address
  logic [7:0]  reg_wdata;   // write data
  logic        reg_wr;      // one-cycle write strobe
  logic        reg_rd;      // one-cycle read strobe
  logic [7:0]  reg_rdata;   // read data
  logic        reg_rvalid;  // one-cycle read answer
  logic [15:0] lane_bit;    // one serial bit per lane per clock

  modport dev (input reg_addr, reg_wdata, reg_wr, reg_rd, lane_bit,
               output reg_rdata, reg_rvalid);
  modport host (output reg_addr, reg_wdata, reg_wr, reg_rd, lane_bit,
                input reg_rdata, reg_rvalid);
endinterface : sbt_link_if
`default_nettype wire

// >>> sbt_lane_checker.sv
// sbt_lane_checker: self-synchronising prbs7 checker with saturating count
// assumes: one received bit per clock; enable comes from a flip-flop
`timescale 1ns/100ps
`default_nettype none
module sbt_lane_checker
  import sbt_pkg::*;
(
  input  wire logic       clk_i,     // 200 MHz clock
  input  wire logic       rst_n_i,   // synchronous reset, active low
  input  wire logic       enable_i,  // error_test_enable
  input  wire logic       bit_i,     // received lane bit
  output logic      [7:0] count_o    // lane_error_count
);
  // all state of the checker
  typedef struct packed {
    logic       prev_en;  // enable delayed, for edge detection
    logic [2:0] fill;     // bits loaded while locking
    logic       locked;   // reference generator running
    logic [6:0] lfsr;     // reference pattern state
    logic [7:0] cnt;      // error count
  } sbt_chk_t;

  sbt_chk_t st;       // registered state
  sbt_chk_t next_st;  // next state
  logic     expect_b; // predicted bit

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    next_st  = st;
    expect_b = st.lfsr[6] ^ st.lfsr[5];
    next_st.prev_en = enable_i;
    if (enable_i && !st.prev_en) begin
      // rising edge: clear and start locking again
      next_st.cnt    = '0;
      next_st.fill   = '0;
      next_st.locked = 1'b0;
    end else if (enable_i && !st.locked) begin
      // load received bits as the seed
      next_st.lfsr = {st.lfsr[5:0], bit_i};
      next_st.fill = st.fill + 3'd1;
      if (st.fill == 3'(SBT_PRBS_LEN - 1)) begin
        next_st.locked = 1'b1;
      end
    end else if (enable_i) begin
      // free running compare
      next_st.lfsr = {st.lfsr[5:0], expect_b};
      if ((bit_i != expect_b) && (st.cnt != SBT_CNT_MAX)) begin
        next_st.cnt = st.cnt + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o = st.cnt;  // straight from the flip-flops
endmodule : sbt_lane_checker
`default_nettype wire

// >>> sbt_device.sv
// sbt_device: receiver control register and per-lane bit-error checkers
// assumes: controller uses the register port with one-cycle strobes and
// the lanes carry prbs7 bits, one per clock
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - bit 0 of test control enables counters
// - configure, pattern, link enable, then test
// - writing enable 0 then 1 clears counters
// - checker self-locks after enable rising edge
// - one 8-bit count per lane, lane 0 lowest
// - counters saturate at 255 until cleared
// - ignore counts on disabled or spare lanes
// - host times measurement, computes error rate
// - change receiver control only with link off
// - clock recovery setting bits 6-4, reset four
// - settings 0-3 are second-order loops
// - settings map to vote thresholds and settling
// - bit 1 enables offset calibration, resets one
// - bit 0 enables loss-of-signal detect, resets one
module sbt_device
  import sbt_pkg::*;
(
  input  wire logic        clk_i,                        // 200 MHz clock
  input  wire logic        rst_n_i,                      // synchronous reset, active low
  sbt_link_if.dev          link,                         // register port and lanes
  output logic             error_test_enable_o,          // counters running
  output logic       [2:0] clock_recovery_setting_o,     // raw setting
  output logic       [3:0] vote_threshold_o,             // recovery vote threshold
  output logic             second_order_o,               // second-order loop selected
  output logic      [10:0] settle_ui_o,                  // settling time in unit intervals
  output logic             offset_cal_enable_o,          // offset calibration on
  output logic             signal_loss_detect_enable_o   // loss-of-signal detector on
);
  // all state of the register block
  typedef struct packed {
    logic [7:0]  test_ctrl;  // bit_error_test_control
    logic [7:0]  rx_ctrl;    // serdes_receiver_control
    logic [7:0]  rdata;      // read answer data
    logic        rvalid;     // read answer strobe
    logic [3:0]  vote;       // decoded threshold
    logic        order2;     // decoded loop order
    logic [10:0] settle;     // decoded settling time
  } sbt_dev_t;

  sbt_dev_t                   st;        // registered state
  sbt_dev_t                   next_st;   // next state
  logic [SBT_LANES-1:0][7:0]  lane_cnt;  // per-lane counts
  logic [2:0]                 cdr_next;  // setting after this cycle's write
  logic [7:0]                 rd_mux;    // read data selection

  ////////////////////////////////////////////////////////////////////////////
  // one checker per lane
  for (genvar g = 0; g < SBT_LANES; g++) begin : g_lane
    sbt_lane_checker u_chk (
      .clk_i    (clk_i),
      .rst_n_i  (rst_n_i),
      .enable_i (st.test_ctrl[SBT_TEST_EN_BIT]),
      .bit_i    (link.lane_bit[g]),
      .count_o  (lane_cnt[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // read selection, register writes and clock recovery decode
  always_comb begin
    next_st = st;
    rd_mux  = 8'h00;  // unmapped addresses read zero
    if (link.reg_addr == SBT_ADDR_TEST_CTRL) begin
      rd_mux = st.test_ctrl;
    end else if (link.reg_addr == SBT_ADDR_RX_CTRL) begin
      rd_mux = st.rx_ctrl;
    end else if (link.reg_addr[11:4] == SBT_ADDR_LANE_CNT[11:4]) begin
      rd_mux = lane_cnt[link.reg_addr[3:0]];
    end
    // write port; reserved bits are stored as read/write
    if (link.reg_wr && (link.reg_addr == SBT_ADDR_TEST_CTRL)) begin
      next_st.test_ctrl = link.reg_wdata;
    end
    if (link.reg_wr && (link.reg_addr == SBT_ADDR_RX_CTRL)) begin
      next_st.rx_ctrl = link.reg_wdata;
    end
    // read answer one cycle after the strobe
    next_st.rvalid = link.reg_rd;
    if (link.reg_rd) begin
      next_st.rdata = rd_mux;
    end
    // decode from the value being stored, so outputs track the register
    cdr_next = next_st.rx_ctrl[SBT_CDR_LSB +: 3];
    next_st.order2 = !cdr_next[2];
    next_st.settle = SBT_SETTLE_FAST_UI;
    case (cdr_next)
      3'd0:    next_st.vote = 4'd15;
      3'd1:    next_st.vote = 4'd7;
      3'd2:    next_st.vote = 4'd3;
      3'd3:    next_st.vote = 4'd1;
      3'd4:    next_st.vote = 4'd15;
      3'd5:    next_st.vote = 4'd3;
      3'd6:    next_st.vote = 4'd1;
      default: begin
        next_st.vote   = 4'd7;
        next_st.settle = SBT_SETTLE_SLOW_UI;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st.test_ctrl <= SBT_TEST_CTRL_RST;
      st.rx_ctrl   <= SBT_RX_CTRL_RST;
      st.rdata     <= 8'h00;
      st.rvalid    <= 1'b0;
      st.vote      <= 4'd15;              // decode of reset setting four
      st.order2    <= 1'b0;
      st.settle    <= SBT_SETTLE_FAST_UI;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from flip-flops
  assign link.reg_rdata                = st.rdata;
  assign link.reg_rvalid               = st.rvalid;
  assign error_test_enable_o           = st.test_ctrl[SBT_TEST_EN_BIT];
  assign clock_recovery_setting_o      = st.rx_ctrl[SBT_CDR_LSB +: 3];
  assign vote_threshold_o              = st.vote;
  assign second_order_o                = st.order2;
  assign settle_ui_o                   = st.settle;
  assign offset_cal_enable_o           = st.rx_ctrl[SBT_OC_BIT];
  assign signal_loss_detect_enable_o   = st.rx_ctrl[SBT_LOS_BIT];
endmodule : sbt_device
`default_nettype wire

// >>> sbt_properties.sv
// sbt_properties: checks on the device register port of the link
// assumes: plain copies of the link signals, one clock domain
`timescale 1ns/100ps
`default_nettype none
module sbt_properties
  import sbt_pkg::*;
(
  input  wire logic        clk_i,      // 200 MHz clock
  input  wire logic        rst_n_i,    // sync reset, active low
  input  wire logic [11:0] reg_addr,   // register address
  input  wire logic  [7:0] reg_wdata,  // write data
  input  wire logic        reg_wr,     // write strobe
  input  wire logic        reg_rd,     // read strobe
  input  wire logic  [7:0] reg_rdata,  // read data
  input  wire logic        reg_rvalid  // read answer
);
  logic [7:0] sh_test;  // expected test control
  logic [7:0] sh_rx;    // expected receiver control
  logic       unmap;    // address outside the map
  assign unmap = (reg_addr != SBT_ADDR_TEST_CTRL) && (reg_addr != SBT_ADDR_RX_CTRL)
    && (reg_addr[11:4] != SBT_ADDR_LANE_CNT[11:4]);
  //////////////////////////////////////////////////////////////////////////
  // shadow copies; lane counter writes never land here
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sh_test <= SBT_TEST_CTRL_RST;
      sh_rx   <= SBT_RX_CTRL_RST;
    end else if (reg_wr && reg_addr == SBT_ADDR_TEST_CTRL) begin
      sh_test <= reg_wdata;
    end else if (reg_wr && reg_addr == SBT_ADDR_RX_CTRL) begin
      sh_rx <= reg_wdata;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  //////////////////////////////////////////////////////////////////////////
  // read port timing and contents, strobe exclusion and write strobe length
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  chk_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without read");
  chk_rdata_hold: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved between reads");
  chk_test_rd: assert property (reg_rd && reg_addr == SBT_ADDR_TEST_CTRL |=>
    reg_rdata == sh_test) else $error("test control read wrong");
  chk_rx_rd: assert property (reg_rd && reg_addr == SBT_ADDR_RX_CTRL |=>
    reg_rdata == sh_rx) else $error("receiver control read wrong");
  chk_unmapped_zero: assert property (reg_rd && unmap |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_strobe_excl: assert property (!(reg_wr && reg_rd))
    else $error("write and read strobes together");
  chk_wr_single: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than a cycle");
endmodule : sbt_properties
`default_nettype wire

// >>> tb_top.sv
// tb_top: drives the controller over axi4-lite and watches the device
// assumes: both ends joined by one link interface, one clock
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import sbt_pkg::*;
;
  logic        clk_i, rst_n_i;                            // clock, reset
  logic        awvalid, wvalid, bready, arvalid, rready;  // master strobes
  logic        awready, wready, bvalid, arready, rvalid;  // slave answers
  logic  [3:0] awaddr, araddr;                            // addresses
  logic [31:0] wdata, rdata, sd;                          // data, last read
  logic  [1:0] bresp, rresp;                              // responses
  logic        en_o, so_o, oc_o, los_o;                   // device flags
  logic  [2:0] cdr_o;                                     // recovery setting
  logic  [3:0] vt_o;                                      // vote threshold
  logic [10:0] st_o;                                      // settling time
  logic  [3:0] vt_tab [0:7] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'hf, 4'h3, 4'h1, 4'h7};
  int          n_errors, n_compared;                      // tallies
  sbt_link_if link ();
  sbt_host sbt_host_inst (.clk_i, .rst_n_i, .link(link), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  sbt_device sbt_device_inst (.clk_i, .rst_n_i, .link(link), .error_test_enable_o(en_o),
    .clock_recovery_setting_o(cdr_o), .vote_threshold_o(vt_o), .second_order_o(so_o),
    .settle_ui_o(st_o), .offset_cal_enable_o(oc_o), .signal_loss_detect_enable_o(los_o));
  sbt_properties sbt_properties_inst (.clk_i, .rst_n_i, .reg_addr(link.reg_addr),
    .reg_wdata(link.reg_wdata), .reg_wr(link.reg_wr), .reg_rd(link.reg_rd),
    .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid));
  //////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    #250000;
    n_errors++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus cycles
  task automatic close_out();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  // address and data offered together, each held until taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'b1;
    do @(posedge clk_i); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    while (!bvalid) @(posedge clk_i);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a);
    @(posedge clk_i);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge clk_i); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk_i);
    sd = rdata;
    rready <= 1'b0;
  endtask : axi_rd
  // device access through the command register, then poll busy
  task automatic dev_op(input logic [11:0] a, input logic [7:0] d, input logic rd);
    axi_wr(SBT_H_CMD, {6'h00, rd, !rd, d, 4'h0, a});
    do axi_rd(SBT_H_STAT); while (sd[8]);
  endtask : dev_op
  //////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    dev_op(SBT_ADDR_TEST_CTRL, 8'h00, 1'b1);
    cmp(sd[7:0], 8'h00);
    dev_op(SBT_ADDR_RX_CTRL, 8'h00, 1'b1);
    cmp(sd[7:0], 8'h43);
    cmp({oc_o, los_o, so_o, cdr_o, vt_o, st_o}, {3'b110, 3'h4, 4'hf, 11'h024});
  endtask : t_reset
  // every recovery setting, calibration and detect bits toggled
  task automatic t_cdr();
    logic [3:0] s;
    for (s = 4'h0; s < 4'h8; s++) begin
      dev_op(SBT_ADDR_RX_CTRL, {1'b0, s[2:0], 2'b00, s[0], s[1]}, 1'b0);
      cmp({oc_o, los_o, so_o, cdr_o, vt_o, st_o}, {s[0], s[1], s < 4'h4, s[2:0],
        vt_tab[s[2:0]], (s == 4'h7) ? 11'h5f4 : 11'h024});
      dev_op(SBT_ADDR_RX_CTRL, 8'h00, 1'b1);
      cmp(sd[7:0], {1'b0, s[2:0], 2'b00, s[0], s[1]});
    end
  endtask : t_cdr
  // clean pattern counts nothing; receiver control locked while link on
  task automatic t_clean();
    logic [4:0] l;
    dev_op(SBT_ADDR_TEST_CTRL, 8'h01, 1'b0);
    cmp({sd[9], en_o}, 2'b10);
    axi_wr(SBT_H_TX, 32'h0000_0001);
    dev_op(SBT_ADDR_TEST_CTRL, 8'h01, 1'b0);
    cmp(en_o, 1'b1);
    dev_op(SBT_ADDR_RX_CTRL, 8'h00, 1'b0);
    cmp({sd[9], oc_o}, 2'b11);
    for (l = 5'h00; l < 5'h10; l++) begin
      dev_op(SBT_ADDR_LANE_CNT + l, 8'h00, 1'b1);
      cmp(sd[7:0], 8'h00);
    end
  endtask : t_clean
  // one flipped bit on lanes 0 and 2 counts once each, lane 1 untouched
  task automatic t_inject();
    logic [1:0] l;
    axi_wr(SBT_H_TX, 32'h0005_0001);
    for (l = 2'h0; l < 2'h3; l++) begin
      dev_op(SBT_ADDR_LANE_CNT + l, 8'h00, 1'b1);
      cmp(sd[7:0], {7'h00, l != 2'h1});
    end
  endtask : t_inject
  // saturation, hold while off, restart on re-enable
  task automatic t_sat();
    repeat (260) axi_wr(SBT_H_TX, 32'h0008_0001);
    dev_op(SBT_ADDR_LANE_CNT + 12'h3, 8'h00, 1'b1);
    cmp(sd[7:0], SBT_CNT_MAX);
    dev_op(SBT_ADDR_TEST_CTRL, 8'h00, 1'b0);
    axi_rd(SBT_H_TIMER);
    cmp(sd, 32'h0);
    dev_op(SBT_ADDR_LANE_CNT + 12'h3, 8'h12, 1'b0);
    dev_op(SBT_ADDR_LANE_CNT + 12'h3, 8'h00, 1'b1);
    cmp(sd[7:0], SBT_CNT_MAX);
    dev_op(SBT_ADDR_TEST_CTRL, 8'h01, 1'b0);
    dev_op(SBT_ADDR_LANE_CNT + 12'h3, 8'h00, 1'b1);
    cmp(sd[7:0], 8'h00);
    axi_rd(SBT_H_TIMER);
    cmp(sd != 32'h0, 1'b1);
    dev_op(12'h1a1, 8'h00, 1'b1);
    cmp(sd[7:0], 8'h00);
  endtask : t_sat
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h0;
    n_errors = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_cdr();
    t_clean();
    t_inject();
    t_sat();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
